//--- hdl/dim_top.sv
/*
 * Digital input mapping: ten filtered, polarity-corrected input
 * terminals, a forced-input word and per-terminal function routing.
 * Assumes a plain register port on the 10 MHz clock; terminal pins
 * are asynchronous and are synchronised here.
 */
`timescale 1ns/10ps
`default_nettype none
`include "dim_cfg.svh"

module dim_top
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // register port
    input wire logic [`DIM_ADDR_W-1:0] i_addr,
    input wire logic [`DIM_DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [`DIM_DATA_W-1:0] o_rdata,
    // terminals
    input wire logic [`DIM_NUM_IN-1:0] i_input_terminal,
    // results
    output logic [`DIM_NUM_IN-1:0] o_valid,
    output logic [`DIM_NUM_FUNC-1:0] o_func_active
);

    ////////////////////////////////////////////////////////////////////////

    dim_pkg::dim_state_s q;
    dim_pkg::dim_state_s d;

    // filter threshold of one terminal
    function automatic dim_pkg::dim_filt_t thr_of(input int idx,
                                                 input dim_pkg::dim_state_s s);
        if (idx >= `DIM_FAST_LO)
        begin
            return s.fast_filt;
        end
        return s.slow_filt;
    endfunction : thr_of

    // zero filter time is not stored; it floors at one
    function automatic dim_pkg::dim_filt_t filt_of(input logic [`DIM_DATA_W-1:0] w);
        if (w[`DIM_FILT_W-1:0] == 15'h0000)
        begin
            return `DIM_FILT_MIN;
        end
        return w[`DIM_FILT_W-1:0];
    endfunction : filt_of

    // function-select index, or -1 for other addresses
    function automatic int func_idx(input logic [`DIM_ADDR_W-1:0] a);
        if (a >= `DIM_REG_FUNC_BASE && a < `DIM_REG_FUNC_BASE + 8'h0A)
        begin
            return int'(a - `DIM_REG_FUNC_BASE);
        end
        return -1;
    endfunction : func_idx

    ////////////////////////////////////////////////////////////////////////

    always_comb
    begin
        int fi;
        int ri;
        fi = 0;
        ri = 0;
        d = q;
        d.sync1 = i_input_terminal;
        d.sync2 = q.sync1;

        // microsecond tick
        d.tick = 1'b0;
        if (q.tick_cnt == 4'(`DIM_CYC_PER_US - 1))
        begin
            d.tick_cnt = 4'h0;
            d.tick = 1'b1;
        end
        else
        begin
            d.tick_cnt = q.tick_cnt + 4'h1;
        end

        // spike filter: level must differ for the whole filter time
        for (int i = 0; i < `DIM_NUM_IN; i++)
        begin
            if (q.sync2[i] == q.stable[i])
            begin
                d.cnt[i] = 15'h0000;
            end
            else if (q.tick)
            begin
                if (16'(q.cnt[i]) + 16'h0001 >= 16'(thr_of(i, q)))
                begin
                    d.stable[i] = q.sync2[i];
                    d.cnt[i] = 15'h0000;
                end
                else
                begin
                    d.cnt[i] = q.cnt[i] + 15'h0001;
                end
            end
        end

        // valid state
        d.valid = ~(q.stable ^ q.pol) | q.force_w;

        // routing to function codes
        d.fvec = '0;
        for (int i = 0; i < `DIM_NUM_IN; i++)
        begin
            if (q.valid[i])
            begin
                d.fvec[q.func[i]] = 1'b1;
            end
        end

        // register writes
        fi = func_idx(i_addr);
        if (i_wr)
        begin
            if (fi >= 0)
            begin
                if (i_wdata > 16'(`DIM_FUNC_MAX))
                begin
                    d.func[fi] = `DIM_FUNC_MAX;
                end
                else
                begin
                    d.func[fi] = i_wdata[`DIM_FUNC_W-1:0];
                end
            end
            unique case (i_addr)
                `DIM_REG_FORCE: d.force_w = i_wdata[`DIM_NUM_IN-1:0];
                `DIM_REG_FAST_FILT: d.fast_filt = filt_of(i_wdata);
                `DIM_REG_SLOW_FILT: d.slow_filt = filt_of(i_wdata);
                `DIM_REG_POL: d.pol = i_wdata[`DIM_NUM_IN-1:0];
                default: d.pol = q.pol;
            endcase
        end

        // register reads, one cycle later; unmapped reads zero
        d.rdata = '0;
        ri = func_idx(i_addr);
        if (i_rd)
        begin
            if (ri >= 0)
            begin
                d.rdata = 16'(q.func[ri]);
            end
            unique case (i_addr)
                `DIM_REG_VALID: d.rdata = 16'(q.valid);
                `DIM_REG_FORCE: d.rdata = 16'(q.force_w);
                `DIM_REG_LEVEL: d.rdata = 16'(q.stable);
                `DIM_REG_FAST_FILT: d.rdata = 16'(q.fast_filt);
                `DIM_REG_SLOW_FILT: d.rdata = 16'(q.slow_filt);
                `DIM_REG_POL: d.rdata = 16'(q.pol);
                default: d.rdata = d.rdata;
            endcase
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            q <= '0;
            q.func[1] <= `DIM_FUNC2_RST;
            q.force_w <= `DIM_FORCE_RST;
            q.pol <= `DIM_POL_RST;
            q.fast_filt <= `DIM_FAST_FILT_RST;
            q.slow_filt <= `DIM_SLOW_FILT_RST;
            // low level with active-low default reads as on; filter settles
            q.stable <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    assign o_rdata = q.rdata;
    assign o_valid = q.valid;
    assign o_func_active = q.fvec;

    ////////////////////////////////////////////////////////////////////////

    logic wr_func_big;
    assign wr_func_big = i_wr && (func_idx(i_addr) == 0) && (i_wdata > 16'(`DIM_FUNC_MAX));

    func_clamp_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        wr_func_big |=> q.func[0] == `DIM_FUNC_MAX)
        else $error("function code not clamped to 99");

    sequence fast_flip_s;
        q.sync2[9] != q.stable[9] && q.tick && q.cnt[9] + 15'h0001 >= q.fast_filt;
    endsequence

    fast_sel_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        fast_flip_s |=> q.stable[9] == $past(q.sync2[9]))
        else $error("fast terminal not settled on fast filter time");

    valid_word_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        i_rd && i_addr == `DIM_REG_VALID |=> o_rdata == 16'($past(q.valid)))
        else $error("valid word read wrong");

    force_on_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        i_wr && i_addr == `DIM_REG_FORCE && i_wdata[3] |=> ##1 o_valid[3])
        else $error("forced terminal not on");

    filter_hold_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        q.sync2[0] == q.stable[0] |=> $stable(q.stable[0]))
        else $error("slow terminal changed without a differing level");

    pol_high_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        q.pol[2] && !q.force_w[2] |=> o_valid[2] == $past(q.stable[2]))
        else $error("active-high terminal wrong");

    route_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        q.valid[0] |=> o_func_active[$past(q.func[0])])
        else $error("valid terminal not routed");

    slow_wait_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        $rose(q.stable[0]) |-> $past(q.cnt[0]) + 15'h0001 >= $past(q.slow_filt))
        else $error("slow terminal settled too early");

    ////////////////////////////////////////////////////////////////////////

    localparam int TICK_CYC = `DIM_CYC_PER_US;

    logic wr_func_ok;
    assign wr_func_ok = i_wr && (func_idx(i_addr) == 0) && (i_wdata <= 16'(`DIM_FUNC_MAX));

    sequence force_wr_s;
        i_wr && i_addr == `DIM_REG_FORCE;
    endsequence

    sequence level_rd_s;
        i_rd && i_addr == `DIM_REG_LEVEL;
    endsequence

    // reset checks carry no disable, they watch the reset itself
    func_reset_a: assert property (
        @(posedge i_clk)
        !i_rst_n |=> q.func[1] == `DIM_FUNC2_RST && q.func[0] == `DIM_FUNC_RST)
        else $error("function code reset value wrong");

    filt_reset_a: assert property (
        @(posedge i_clk)
        !i_rst_n |=> q.fast_filt == `DIM_FAST_FILT_RST && q.slow_filt == `DIM_SLOW_FILT_RST)
        else $error("filter time reset value wrong");

    ctrl_reset_a: assert property (
        @(posedge i_clk)
        !i_rst_n |=> q.pol == `DIM_POL_RST && q.force_w == `DIM_FORCE_RST)
        else $error("polarity or force reset value wrong");

    func_store_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        wr_func_ok |=> q.func[0] == $past(i_wdata[`DIM_FUNC_W-1:0]))
        else $error("function code not stored");

    force_store_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        force_wr_s |=> q.force_w == $past(i_wdata[`DIM_NUM_IN-1:0]))
        else $error("force word not stored");

    force_or_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        q.force_w[5] |=> o_valid[5])
        else $error("forced terminal six not on");

    pol_low_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        !q.pol[0] && !q.force_w[0] |=> o_valid[0] == !$past(q.stable[0]))
        else $error("active-low terminal wrong");

    rdata_idle_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        !i_rd |=> o_rdata == 16'h0000)
        else $error("read data stood past its cycle");

    level_word_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        level_rd_s |=> o_rdata == 16'($past(q.stable)))
        else $error("actual level word read wrong");

    fast_floor_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        i_wr && i_addr == `DIM_REG_FAST_FILT && i_wdata[`DIM_FILT_W-1:0] == 15'h0000
        |=> q.fast_filt == `DIM_FILT_MIN)
        else $error("zero filter time not floored");

    fast_wait_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        $changed(q.stable[9]) |-> $past(q.cnt[9]) + 15'h0001 >= $past(q.fast_filt))
        else $error("fast terminal settled too early");

    // filters count microseconds, so the tick period is their time base
    tick_gap_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        q.tick |-> ##TICK_CYC q.tick)
        else $error("microsecond tick period wrong");

    tick_single_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        q.tick |=> !q.tick)
        else $error("microsecond tick longer than one cycle");

    for (genvar g = 0; g < `DIM_NUM_IN; g = g + 1)
    begin : g_term_chk
        func_range_a: assert property (
            @(posedge i_clk) disable iff (!i_rst_n)
            q.func[g] <= `DIM_FUNC_MAX)
            else $error("function code above 99");

        cnt_restart_a: assert property (
            @(posedge i_clk) disable iff (!i_rst_n)
            q.sync2[g] == q.stable[g] |=> q.cnt[g] == 15'h0000)
            else $error("filter count not restarted");

        route_each_a: assert property (
            @(posedge i_clk) disable iff (!i_rst_n)
            q.valid[g] |=> o_func_active[$past(q.func[g])])
            else $error("valid terminal not routed to its code");
    end

    for (genvar g = 0; g < `DIM_FAST_LO; g = g + 1)
    begin : g_slow_chk
        slow_sel_a: assert property (
            @(posedge i_clk) disable iff (!i_rst_n)
            q.sync2[g] != q.stable[g] && q.tick && q.cnt[g] + 15'h0001 >= q.slow_filt
            |=> q.stable[g] == $past(q.sync2[g]))
            else $error("slow terminal not settled on slow filter time");
    end

endmodule : dim_top

`default_nettype wire

//--- hdl/dim_cfg.svh
/*
 * Constants of the digital input mapping block: register indices,
 * reset values, field widths and timing counts.
 * Assumes a 10 MHz system clock.
 */
`ifndef DIM_CFG_SVH
`define DIM_CFG_SVH

// widths
`define DIM_NUM_IN 10
`define DIM_ADDR_W 8
`define DIM_DATA_W 16
`define DIM_FUNC_W 7
`define DIM_FILT_W 15
`define DIM_NUM_FUNC 100

// register indices
`define DIM_REG_FUNC_BASE 8'h01
`define DIM_REG_VALID 8'h0D
`define DIM_REG_FORCE 8'h0E
`define DIM_REG_LEVEL 8'h0F
`define DIM_REG_FAST_FILT 8'h10
`define DIM_REG_SLOW_FILT 8'h11
`define DIM_REG_POL 8'h15

// reset values and limits
`define DIM_FUNC_MAX 7'h63
`define DIM_FUNC_RST 7'h00
`define DIM_FUNC2_RST 7'h2A
`define DIM_FORCE_RST 10'h000
`define DIM_POL_RST 10'h000
`define DIM_FAST_FILT_RST 15'h000A
`define DIM_SLOW_FILT_RST 15'h03E8
`define DIM_FILT_MIN 15'h0001

// timing
`define DIM_CLK_HZ 10000000
`define DIM_US_PER_S 1000000
`define DIM_CYC_PER_US (`DIM_CLK_HZ / `DIM_US_PER_S)
`define DIM_TICK_W 4
// terminals nine and ten are the fast ones
`define DIM_FAST_LO 8

`endif

//--- hdl/dim_pkg.sv
/*
 * Types of the digital input mapping block.
 * Assumes dim_cfg.svh is on the include path.
 */
`include "dim_cfg.svh"

package dim_pkg;

    typedef logic [`DIM_NUM_IN-1:0] dim_bits_t;
    typedef logic [`DIM_FUNC_W-1:0] dim_func_t;
    typedef logic [`DIM_FILT_W-1:0] dim_filt_t;

    typedef struct packed {
        dim_bits_t sync1;
        dim_bits_t sync2;
        dim_bits_t stable;
        dim_filt_t [`DIM_NUM_IN-1:0] cnt;
        logic [`DIM_TICK_W-1:0] tick_cnt;
        logic tick;
        dim_func_t [`DIM_NUM_IN-1:0] func;
        dim_bits_t force_w;
        dim_bits_t pol;
        dim_filt_t fast_filt;
        dim_filt_t slow_filt;
        logic [`DIM_DATA_W-1:0] rdata;
        dim_bits_t valid;
        logic [`DIM_NUM_FUNC-1:0] fvec;
    } dim_state_s;

endpackage : dim_pkg

//--- sim/dim_switch_model.sv
/*
 * Model of the external switches that drive the ten input terminals.
 * Assumes the bench commands the wanted levels on the system clock.
 */
`timescale 1ns/10ps
`default_nettype none

module dim_switch_model
(
    // clock
    input wire logic i_clk,
    // wanted levels
    input wire logic [9:0] i_level,
    // terminal pins
    output logic [9:0] o_terminal
);
    // one flop of contact delay, so pins never move on the bench's own edge
    always_ff @(posedge i_clk)
    begin
        o_terminal <= i_level;
    end
endmodule : dim_switch_model

`default_nettype wire

//--- sim/digital_input_mapping_bench.sv
/*
 * Bench for the digital input mapping block: registers, force word,
 * filters and polarity. Assumes dim_top and dim_switch_model compiled.
 */
`timescale 1ns/10ps
`default_nettype none
`include "dim_cfg.svh"

module digital_input_mapping_bench;
    logic clk, rst_n, wr, rd;
    logic [7:0] addr;
    logic [15:0] wdata, rdata;
    logic [9:0] lvl, term, valid;
    logic [99:0] fact;
    int miscompares = 0;
    int check_count = 0;

    dim_switch_model sw (.i_clk(clk), .i_level(lvl), .o_terminal(term));
    dim_top uut (.i_clk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_input_terminal(term),
        .o_valid(valid), .o_func_active(fact));

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    // data stands only in the cycle after the strobe
    task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask : rd_chk

    task automatic wait_chk(input int n, input logic [15:0] exp);
        repeat (n) @(posedge clk);
        #1;
        chk({6'h00, valid}, exp);
    endtask : wait_chk

    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : final_report

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        for (int i = 1; i <= 10; i++)
            rd_chk(8'(i), (i == 2) ? 16'h002A : 16'h0000);
        rd_chk(`DIM_REG_FORCE, 16'h0000);
        rd_chk(`DIM_REG_POL, 16'h0000);
        rd_chk(`DIM_REG_FAST_FILT, 16'h000A);
        rd_chk(`DIM_REG_SLOW_FILT, 16'h03E8);
        chk({6'h00, valid}, 16'h03FF);
        wr_reg(`DIM_REG_VALID, 16'h0000);
        rd_chk(`DIM_REG_VALID, 16'h03FF);
    endtask : t_reset

    task automatic t_func();
        wr_reg(8'h03, 16'h0078);
        rd_chk(8'h03, 16'h0063);
        wr_reg(8'h03, 16'h0000);
        wr_reg(8'h01, 16'h00FF);
        rd_chk(8'h01, 16'h0063);
        wr_reg(8'h01, 16'h0000);
        rd_chk(8'h01, 16'h0000);
        rd_chk(8'h20, 16'h0000);
    endtask : t_func

    // active high on all pins so only the force word shows
    task automatic t_force();
        wr_reg(`DIM_REG_POL, 16'h03FF);
        wr_reg(`DIM_REG_FORCE, 16'h002A);
        wait_chk(3, 16'h002A);
        rd_chk(`DIM_REG_VALID, 16'h002A);
        chk({15'h0000, fact[42]}, 16'h0001);
        chk({15'h0000, fact[0]}, 16'h0001);
        wr_reg(`DIM_REG_FORCE, 16'h0000);
        wait_chk(3, 16'h0000);
    endtask : t_force

    task automatic t_filter();
        wr_reg(`DIM_REG_FAST_FILT, 16'h0000);
        rd_chk(`DIM_REG_FAST_FILT, 16'h0001);
        wr_reg(`DIM_REG_FAST_FILT, 16'h0002);
        wr_reg(`DIM_REG_SLOW_FILT, 16'h0005);
        rd_chk(`DIM_REG_SLOW_FILT, 16'h0005);
        @(posedge clk);
        lvl <= 10'h301;
        wait_chk(40, 16'h0300);
        wait_chk(40, 16'h0301);
        rd_chk(`DIM_REG_LEVEL, 16'h0301);
    endtask : t_filter

    task automatic t_spike();
        @(posedge clk);
        lvl <= 10'h303;
        repeat (20) @(posedge clk);
        lvl <= 10'h301;
        wait_chk(80, 16'h0301);
    endtask : t_spike

    task automatic t_pol();
        wr_reg(`DIM_REG_POL, 16'h03FE);
        wait_chk(3, 16'h0300);
    endtask : t_pol

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        rst_n = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        addr = 8'h00;
        wdata = 16'h0000;
        lvl = 10'h000;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        t_reset();
        t_func();
        t_force();
        t_filter();
        t_spike();
        t_pol();
        final_report();
    end

    // whole run needs well under a thousand cycles
    initial
    begin
        repeat (3000) @(posedge clk);
        miscompares++;
        final_report();
    end
endmodule : digital_input_mapping_bench

`default_nettype wire
